/* spl_host_model.sv */
// Host master model for the serial link.
`timescale 1ns/1ns
module spl_host_model
	import spl_pkg::*;
(
	// Pins toward the device.
	output spl_link_in_s link_in,
	// Pins from the device and scheme.
	input wire spl_link_out_s link_out,
	input wire logic launch_on_falling
);
	initial
		link_in = 3'h2;
	// =====
	// Clock idles so a frame always opens on a launch edge.
	task automatic select();
		link_in.sclk = launch_on_falling;
		#80;
		link_in.cs_n = 1'b0;
	endtask : select
	task automatic deselect();
		link_in.cs_n = 1'b1;
		link_in.mosi = ~link_in.mosi;
	endtask : deselect
	// Fewer than eight bits aborts.
	task automatic shift(input spl_byte_t tx, input int nb, output spl_byte_t rx);
		rx = 8'h00;
		for (int i = 0; i < nb; i++)
		begin
			link_in.sclk = ~link_in.sclk;
			link_in.mosi = tx[7-i];
			#80; // Even duty.
			link_in.sclk = ~link_in.sclk;
			rx = {rx[6:0], link_out.miso};
			#80;
		end
	endtask : shift
endmodule : spl_host_model

/* spl_link.sv */
// Device end of the serial host link with power-up and ready handshake.
// Contract
// - Host clocks from zero to 16 MHz; MOSI is taken at any rate in that range, but MISO lags a launch edge by up to three core cycles.
// - Active-low select enables the link; device answers only while selected.
// - Idle with data waiting, the device pulls the interrupt line low.
// - On select the device pulls interrupt low when ready; first wait about 7 ms.
// - Select is asynchronous and is synchronised inside the device.
// - Launch on rising, capture on falling by default; opposite is selectable.
// - About 53 ms after enable the device pulls interrupt low; host waits.
`timescale 1ns/1ns
`include "spl_params.svh"
module spl_link
	import spl_pkg::*;
#(
	parameter int unsigned WAKE_CYC = `SPL_WAKEUP_CYC,
	parameter int unsigned FIRST_CYC = `SPL_FIRST_WRITE_CYC,
	parameter int unsigned DEPTH = `SPL_BUF_DEPTH
)
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Pins from and to the host.
	input wire spl_link_in_s link_in,
	input wire logic module_power_enable,
	output spl_link_out_s link_out,
	// Configuration.
	input wire logic launch_on_falling,
	// Received bytes toward the core.
	output logic rx_valid,
	input wire logic rx_ready,
	output spl_byte_t rx_data,
	// Bytes from the core toward the host.
	input wire logic tx_valid,
	output logic tx_ready,
	input wire spl_byte_t tx_data,
	// Status.
	output logic powered_up
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ========================================================================
	// Pin synchronisers.
	// ========================================================================
	logic [2:0] meta;
	logic [2:0] syn;
	logic pwr_meta;
	logic pwr_s;
	logic sclk_d;
	logic sclk_s;
	logic cs_s;
	logic mosi_s;
	// All link pins pass through the same depth, so data stays aligned to its clock.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= 3'b010;
			syn <= 3'b010;
			pwr_meta <= 1'b0;
			pwr_s <= 1'b0;
			sclk_d <= 1'b0;
		end
		else
		begin
			meta <= link_in;
			syn <= meta;
			pwr_meta <= module_power_enable;
			pwr_s <= pwr_meta;
			sclk_d <= syn[2];
		end
	end
	assign sclk_s = syn[2];
	assign cs_s = syn[1];
	assign mosi_s = syn[0];

	// Edges are found by oversampling, so any host rate down to a stopped clock works.
	logic rise;
	logic fall;
	logic launch;
	logic capture;
	assign rise = sclk_s & ~sclk_d;
	assign fall = ~sclk_s & sclk_d;
	assign launch = launch_on_falling ? fall : rise;
	assign capture = launch_on_falling ? rise : fall;

	// ========================================================================
	// Power-up sequence.
	// ========================================================================
	spl_pwr_e pwr;
	logic [`SPL_CNT_W-1:0] cnt;
	logic first_done;
	logic ready;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwr <= SPL_OFF;
		end
		else if (!pwr_s)
		begin
			pwr <= SPL_OFF;
		end
		else
		begin
			unique case (pwr)
				SPL_OFF: pwr <= SPL_WAKE;
				SPL_WAKE:
				begin
					if (cnt == `SPL_CNT_W'(WAKE_CYC - 1))
					begin
						pwr <= SPL_UP;
					end
				end
				SPL_UP: pwr <= SPL_UP;
				default: pwr <= SPL_OFF;
			endcase
		end
	end

	// One counter serves the wake-up time and the first-write wait.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= '0;
		end
		else if (pwr == SPL_WAKE)
		begin
			cnt <= cnt + 1'b1;
		end
		else if (pwr == SPL_UP && !cs_s && !first_done)
		begin
			cnt <= cnt + 1'b1;
		end
		else
		begin
			cnt <= '0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			first_done <= 1'b0;
		end
		else if (pwr != SPL_UP)
		begin
			first_done <= 1'b0;
		end
		else if (!cs_s && cnt == `SPL_CNT_W'(FIRST_CYC - 1))
		begin
			first_done <= 1'b1;
		end
	end
	assign powered_up = (pwr == SPL_UP);

	// ========================================================================
	// Receive buffer.
	// ========================================================================
	spl_byte_t mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] fill;
	logic buf_full;
	logic push;
	logic pop;
	logic [2:0] bit_cnt;
	spl_byte_t rx_sh;
	assign buf_full = (fill == (AW+1)'(DEPTH));
	assign rx_valid = (fill != '0);
	assign rx_data = mem[rd_ptr];
	assign pop = rx_valid & rx_ready;
	assign push = capture & ~cs_s & (bit_cnt == 3'd7) & ~buf_full;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop)
			begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	always_ff @(posedge core_clk)
	begin
		if (push)
		begin
			mem[wr_ptr] <= {rx_sh[6:0], mosi_s};
		end
	end

	// ========================================================================
	// Shifters.
	// ========================================================================
	logic hold_valid;
	spl_byte_t hold;
	spl_byte_t tx_sh;
	logic load;
	logic miso_q;
	assign load = launch & ~cs_s & (bit_cnt == 3'd0);
	assign tx_ready = ~hold_valid;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hold_valid <= 1'b0;
			hold <= `SPL_IDLE_BYTE;
		end
		else if (tx_valid && !hold_valid)
		begin
			hold_valid <= 1'b1;
			hold <= tx_data;
		end
		else if (load)
		begin
			hold_valid <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_cnt <= 3'd0;
			rx_sh <= `SPL_IDLE_BYTE;
		end
		else if (cs_s)
		begin
			bit_cnt <= 3'd0;
		end
		else if (capture)
		begin
			bit_cnt <= bit_cnt + 3'd1;
			rx_sh <= {rx_sh[6:0], mosi_s};
		end
	end

	// A missing core byte sends the idle byte rather than stale data.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_sh <= `SPL_IDLE_BYTE;
			miso_q <= 1'b0;
		end
		else if (load)
		begin
			miso_q <= hold_valid ? hold[7] : 1'b0;
			tx_sh <= hold_valid ? {hold[6:0], 1'b0} : `SPL_IDLE_BYTE;
		end
		else if (launch && !cs_s)
		begin
			miso_q <= tx_sh[7];
			tx_sh <= {tx_sh[6:0], 1'b0};
		end
	end

	// ========================================================================
	// Interrupt line and output enable.
	// ========================================================================
	// The ready level also waits for buffer room, so a full buffer stalls the host.
	logic irq_q;
	logic oe_q;
	assign ready = first_done & ~buf_full;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_q <= 1'b1;
			oe_q <= 1'b0;
		end
		else
		begin
			oe_q <= ~cs_s & (pwr == SPL_UP);
			if (pwr != SPL_UP)
			begin
				irq_q <= 1'b1;
			end
			else if (cs_s)
			begin
				irq_q <= ~(hold_valid | ~first_done);
			end
			else
			begin
				irq_q <= ~ready;
			end
		end
	end
	// Each pin has its own flop, so the bundle has a single driver.
	assign link_out = '{irq_n: irq_q, miso: miso_q, miso_oe: oe_q};

	// ========================================================================
	// Checks.
	// ========================================================================
	sequence s_first_select;
		$fell(cs_s) ##0 !first_done;
	endsequence
	sequence s_wake_end;
		pwr == SPL_WAKE && cnt == `SPL_CNT_W'(WAKE_CYC - 1) && pwr_s;
	endsequence
	property p_idle_irq;
		@(posedge core_clk) disable iff (!rst_n)
		(pwr == SPL_UP && cs_s && hold_valid) |=> !link_out.irq_n;
	endproperty
	a_idle_irq: assert property (p_idle_irq) else $error("idle data not flagged");
	property p_first_wait;
		@(posedge core_clk) disable iff (!rst_n)
		s_first_select |=> link_out.irq_n [*2];
	endproperty
	a_first_wait: assert property (p_first_wait) else $error("ready too early");
	property p_wake;
		@(posedge core_clk) disable iff (!rst_n)
		s_wake_end |=> powered_up ##1 (cs_s -> !link_out.irq_n);
	endproperty
	a_wake: assert property (p_wake) else $error("wake-up not signalled");
	property p_off;
		@(posedge core_clk) disable iff (!rst_n)
		!pwr_s |=> !powered_up ##1 link_out.irq_n;
	endproperty
	a_off: assert property (p_off) else $error("not shut down");
	property p_deselect;
		@(posedge core_clk) disable iff (!rst_n)
		cs_s |=> !link_out.miso_oe;
	endproperty
	a_deselect: assert property (p_deselect) else $error("driving while idle");
	property p_capture;
		@(posedge core_clk) disable iff (!rst_n)
		(capture && !cs_s) |=> bit_cnt == $past(bit_cnt) + 3'd1;
	endproperty
	a_capture: assert property (p_capture) else $error("capture missed");
	property p_launch;
		@(posedge core_clk) disable iff (!rst_n)
		(launch && !cs_s && !load) |=> link_out.miso == $past(tx_sh[7]);
	endproperty
	a_launch: assert property (p_launch) else $error("wrong bit launched");
	property p_sync;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(cs_s) |=> bit_cnt == 3'd0 ##1 !link_out.miso_oe;
	endproperty
	a_sync: assert property (p_sync) else $error("select not honoured");
	property p_push;
		@(posedge core_clk) disable iff (!rst_n)
		(push && !pop) |=> fill == $past(fill) + 1'b1;
	endproperty
	a_push: assert property (p_push) else $error("byte lost");
endmodule : spl_link

/* spl_link_tb_top.sv */
// Bench for the serial link.
`timescale 1ns/1ns
`include "spl_params.svh"
module spl_link_tb_top
	import spl_pkg::*;
;
	localparam int unsigned WAKE_C = 50;
	localparam int unsigned FIRST_C = 20;
	logic core_clk, rst_n, module_power_enable, launch_on_falling;
	logic rx_valid, rx_ready, tx_valid, tx_ready, powered_up;
	spl_link_in_s link_in;
	spl_link_out_s link_out;
	spl_byte_t rx_data, tx_data, b, got;
	spl_byte_t q[2];
	int bad_count, checks, seed, n;
	spl_link #(.WAKE_CYC(WAKE_C), .FIRST_CYC(FIRST_C), .DEPTH(2)) spl_link_i (
		.core_clk(core_clk), .rst_n(rst_n), .link_in(link_in),
		.module_power_enable(module_power_enable), .link_out(link_out),
		.launch_on_falling(launch_on_falling), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data), .powered_up(powered_up));
	spl_host_model spl_host_model_i (.link_in(link_in), .link_out(link_out),
		.launch_on_falling(launch_on_falling));
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// =====
	task automatic wrap_up();
		if (bad_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	task automatic chk_bit(input string nm, input logic e, input logic s);
		checks++;
		if (s !== e)
		begin
			$display("mismatch %s expected %b seen %b", nm, e, s);
			bad_count++;
		end
	endtask : chk_bit
	task automatic chk_byte(input string nm, input spl_byte_t e, input spl_byte_t s);
		checks++;
		if (s !== e)
		begin
			$display("mismatch %s expected %h seen %h", nm, e, s);
			bad_count++;
		end
	endtask : chk_byte
	task automatic give_up(input string nm);
		$display("mismatch %s expected done seen timeout", nm);
		bad_count++;
		wrap_up();
	endtask : give_up
	// Ready drops once two unread bytes wait.
	function automatic logic busy_at(input int held);
		return held >= 2;
	endfunction : busy_at
	task automatic wait_irq(input int lim, output int k);
		k = 0;
		while (link_out.irq_n !== 1'b0)
		begin
			@(negedge core_clk);
			k++;
			if (k > lim) give_up("irq_n");
		end
	endtask : wait_irq
	task automatic host_sel(input int lim, output int k);
		spl_host_model_i.select();
		repeat (6) @(negedge core_clk);
		wait_irq(lim, k);
	endtask : host_sel
	task automatic core_send(input spl_byte_t d);
		int k = 0;
		@(negedge core_clk);
		tx_valid = 1'b1;
		tx_data = d;
		// Ready is judged at the falling edge, where it has settled.
		while (tx_ready !== 1'b1)
		begin
			@(negedge core_clk);
			k++;
			if (k > 50) give_up("tx_ready");
		end
		@(negedge core_clk);
		tx_valid = 1'b0;
	endtask : core_send
	task automatic core_take(input spl_byte_t d);
		int k = 0;
		@(negedge core_clk);
		while (rx_valid !== 1'b1)
		begin
			@(negedge core_clk);
			k++;
			if (k > 50) give_up("rx_valid");
		end
		chk_byte("rx_data", d, rx_data);
		rx_ready = 1'b1;
		@(negedge core_clk);
		rx_ready = 1'b0;
	endtask : core_take
	// =====
	initial
	begin
		seed = 68779;
		bad_count = 0;
		checks = 0;
		{rst_n, module_power_enable, launch_on_falling, rx_ready, tx_valid} = 5'h00;
		tx_data = 8'h00;
		repeat (8) @(negedge core_clk);
		chk_bit("miso_oe", 1'b0, link_out.miso_oe);
		rst_n = 1'b1;
		repeat (30) @(negedge core_clk);
		chk_bit("powered_up", 1'b0, powered_up);
		chk_bit("irq_n", 1'b1, link_out.irq_n);
		// Power enable rises only after reset has been released for 30 cycles.
		module_power_enable = 1'b1;
		wait_irq(WAKE_C + 10, n);
		chk_bit("wake_time", 1'b1, n >= WAKE_C);
		chk_bit("powered_up", 1'b1, powered_up);
		host_sel(FIRST_C + 20, n);
		chk_bit("first_wait", 1'b1, n + 10 >= FIRST_C);
		spl_host_model_i.deselect();
		for (int m = 0; m < 2; m++)
		begin
			@(negedge core_clk);
			launch_on_falling = m[0];
			host_sel(20, n);
			for (int i = 0; i < 2; i++)
			begin
				q[i] = spl_byte_t'($random(seed));
				spl_host_model_i.shift(q[i], 8, got);
				chk_byte("miso_idle", `SPL_IDLE_BYTE, got);
			end
			repeat (4) @(negedge core_clk);
			chk_bit("irq_n_full", busy_at(2), link_out.irq_n);
			chk_bit("miso_oe", 1'b1, link_out.miso_oe);
			core_take(q[0]);
			core_take(q[1]);
			wait_irq(20, n);
			spl_host_model_i.shift(8'h5a, 3, got);
			spl_host_model_i.deselect();
			repeat (10) @(negedge core_clk);
			chk_bit("rx_valid", 1'b0, rx_valid);
			chk_bit("miso_oe", 1'b0, link_out.miso_oe);
			b = spl_byte_t'($random(seed));
			core_send(b);
			wait_irq(20, n);
			host_sel(20, n);
			q[0] = spl_byte_t'($random(seed));
			spl_host_model_i.shift(q[0], 8, got);
			chk_byte("miso", b, got);
			spl_host_model_i.deselect();
			core_take(q[0]);
		end
		wrap_up();
	end
endmodule : spl_link_tb_top

/* spl_params.svh */
// Timing and layout constants for the serial host link.
`ifndef SPL_PARAMS_SVH
`define SPL_PARAMS_SVH
`define SPL_CLK_KHZ 50000
`define SPL_SCLK_MAX_KHZ 16000
`define SPL_WAKEUP_INTERVAL_MS 53
`define SPL_FIRST_WRITE_READY_INTERVAL_MS 7
`define SPL_WAKEUP_CYC (`SPL_WAKEUP_INTERVAL_MS * `SPL_CLK_KHZ)
`define SPL_FIRST_WRITE_CYC (`SPL_FIRST_WRITE_READY_INTERVAL_MS * `SPL_CLK_KHZ)
`define SPL_BYTE_W 8
`define SPL_BUF_DEPTH 2
`define SPL_CNT_W 22
`define SPL_IDLE_BYTE 8'h00
`endif

/* spl_pkg.sv */
// Types shared by the serial host link.
`include "spl_params.svh"
package spl_pkg;
	typedef enum logic [1:0]
	{
		SPL_OFF = 2'b00,
		SPL_WAKE = 2'b01,
		SPL_UP = 2'b10
	} spl_pwr_e;
	typedef logic [`SPL_BYTE_W-1:0] spl_byte_t;
	typedef struct packed
	{
		logic sclk;
		logic cs_n;
		logic mosi;
	} spl_link_in_s;
	typedef struct packed
	{
		logic irq_n;
		logic miso;
		logic miso_oe;
	} spl_link_out_s;
endpackage : spl_pkg
